// file: common/macres_consts.svh
// Constants of the multiply-accumulate result unit
`ifndef MACRES_CONSTS_SVH
`define MACRES_CONSTS_SVH

// ----------------------------------------------------------------
// Widths and sections
// ----------------------------------------------------------------
`define MACRES_ACC_W      40
`define MACRES_OPND_W     16
`define MACRES_LOW_LSB    0
`define MACRES_MID_LSB    16
`define MACRES_TOP_LSB    32
`define MACRES_TOP_W      8
// Top nine bits examined for overflow
`define MACRES_OVF_LSB    31

// ----------------------------------------------------------------
// Status register layout
// ----------------------------------------------------------------
`define MACRES_FLAGS_W    16
`define MACRES_PRI_OVF_BIT 6
`define MACRES_SEC_OVF_BIT 8
`define MACRES_FLAGS_RST  16'h0000

// ----------------------------------------------------------------
// Saturation and rounding values
// ----------------------------------------------------------------
`define MACRES_SAT_POS    40'h007fffffff
`define MACRES_SAT_NEG    40'hff80000000
`define MACRES_RND_BIAS   40'h0000008000
`define MACRES_ACC_RST    40'h0000000000

`endif

// file: common/macres_pkg.sv
// Types of the multiply-accumulate result unit
package macres_pkg;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP      = 4'h0,
    OP_MUL      = 4'h1,
    OP_MAC_ADD  = 4'h2,
    OP_MAC_SUB  = 4'h3,
    OP_CLEAR    = 4'h4,
    OP_ROUND    = 4'h5,
    OP_SAT      = 4'h6,
    OP_LOAD_LOW = 4'h7,
    OP_LOAD_MID = 4'h8,
    OP_LOAD_TOP = 4'h9
  } macres_op_t;

  // ----------------------------------------------------------------
  // Operand interpretation
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    both_signed_operands   = 2'h0,
    both_unsigned_operands = 2'h1,
    signed_x_unsigned_y    = 2'h2,
    unsigned_x_signed_y    = 2'h3
  } macres_sign_t;

  // One instruction, valid for one cycle
  typedef struct packed {
    logic         valid;
    macres_op_t   op;
    logic         dest_secondary;
    logic         x_from_rbus;
    logic         y_from_feedback;
    macres_sign_t sign_mode;
    logic         rnd;
    logic         cond_true;
  } macres_cmd_t;

endpackage

// file: dv/macres_core_model.sv
// Core-side register file and result bus model
`timescale 1ns/1ns
`default_nettype none
module macres_core_model (
  input  wire logic        clk,
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_sel,
  input  wire logic [15:0] wr_data,
  input  wire logic [1:0]  x_sel,
  input  wire logic [1:0]  y_sel,
  output logic      [15:0] x_regfile,
  output logic      [15:0] y_regfile,
  output logic      [15:0] x_result_bus
);
  logic [15:0] regs [4] = '{default: 16'h0000};
  logic [15:0] rbus = 16'h0000;
  // --------------------------------
  // Writes travel over the result bus
  // --------------------------------
  // Bus is held by the rbus register of this model, so it keeps its last written value
  always @(posedge clk) begin
    if (wr_en) begin
      regs[wr_sel] <= wr_data;
      rbus <= wr_data;
    end
  end
  assign x_regfile = regs[x_sel];
  assign y_regfile = regs[y_sel];
  assign x_result_bus = rbus;
endmodule
`default_nettype wire

// file: dv/macres_unit_tb_top.sv
// Self-checking bench of the multiply-accumulate result unit
`timescale 1ns/1ns
`default_nettype none
module macres_unit_tb_top;
  import macres_pkg::*;
  localparam macres_sign_t SS = both_signed_operands;
  localparam macres_sign_t UNS = both_unsigned_operands;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  macres_cmd_t cmd = '0;
  logic        frac_mode = 1'b0;
  logic [15:0] load_data = 16'h0000;
  logic        wr_en = 1'b0;
  logic [1:0]  wr_sel = 2'h0;
  logic [15:0] wr_data = 16'h0000;
  logic [1:0]  x_sel = 2'h0;
  logic [1:0]  y_sel = 2'h0;
  logic [15:0] rv [4] = '{16'h8000, 16'h7fff, 16'hffff, 16'h4000};
  logic [15:0] x_regfile;
  logic [15:0] y_regfile;
  logic [15:0] x_result_bus;
  logic [15:0] fb;
  logic [15:0] flags;
  logic [39:0] pri;
  logic [39:0] sec;
  logic [39:0] pe = 40'h0;
  logic [39:0] se = 40'h0;
  logic        pv = 1'b0;
  logic        sec_ovf = 1'b0;
  int          num_errors = 0;
  int          check_count = 0;

  always #10 clk = ~clk;

  macres_unit dut (
    .clk                        (clk),
    .arst_n                     (arst_n),
    .cmd                        (cmd),
    .frac_mode                  (frac_mode),
    .x_regfile                  (x_regfile),
    .x_result_bus               (x_result_bus),
    .y_regfile                  (y_regfile),
    .load_data                  (load_data),
    .primary_accumulator        (pri),
    .secondary_accumulator      (sec),
    .secondary_acc_mid_feedback (fb),
    .arith_flags_register       (flags)
  );
  macres_core_model u_core (
    .clk          (clk),
    .wr_en        (wr_en),
    .wr_sel       (wr_sel),
    .wr_data      (wr_data),
    .x_sel        (x_sel),
    .y_sel        (y_sel),
    .x_regfile    (x_regfile),
    .y_regfile    (y_regfile),
    .x_result_bus (x_result_bus)
  );

  // --------------------------------
  // Reference arithmetic and checks
  // --------------------------------
  function automatic logic [39:0] prod(logic [15:0] x, logic [15:0] y,
                                       logic [1:0] m, logic f);
    logic signed [33:0] p;
    p = $signed({x[15] & (m == 2'h0 || m == 2'h2), x}) *
        $signed({y[15] & (m == 2'h0 || m == 2'h3), y});
    prod = {{6{p[33]}}, p};
    if (f && m == 2'h0) prod = prod << 1;
  endfunction
  function automatic logic ov(logic [39:0] v);
    ov = !(&v[39:31]) && |v[39:31];
  endfunction
  task automatic chk(string n, logic [39:0] s, logic [39:0] x);
    check_count++;
    if (s !== x) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic ck();
    chk("primary", pri, pe);
    chk("secondary", sec, se);
    chk("feedback", {24'h0, fb}, {24'h0, se[31:16]});
    chk("flags", {24'h0, flags},
        {24'h0, 7'h0, sec_ovf, 1'b0, pv, 6'h0});
  endtask
  // Issue one instruction; bb leaves it for a back-to-back follower
  task automatic go(macres_op_t o, logic d, logic [1:0] xs,
                    logic [1:0] ys, macres_sign_t m, logic f,
                    logic [15:0] ld, logic r = 1'b0, logic c = 1'b1,
                    logic xb = 1'b0, logic yf = 1'b0, logic bb = 1'b0);
    @(posedge clk);
    x_sel <= xs;
    y_sel <= ys;
    frac_mode <= f;
    load_data <= ld;
    cmd <= '{1'b1, o, d, xb, yf, m, r, c};
    if (!bb) begin
      @(posedge clk);
      cmd <= '0;
      #1;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // --------------------------------
  // Test sequence
  // --------------------------------
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      wr_en <= 1'b1;
      wr_sel <= 2'(i);
      wr_data <= rv[i];
    end
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
    ck();
    pe = prod(rv[0], rv[1], 2'h0, 1'b0);
    go(OP_MUL, 1'b0, 2'h0, 2'h1, SS, 1'b0, 16'h0);
    ck();
    pe = prod(rv[0], rv[1], 2'h0, 1'b1);
    go(OP_MUL, 1'b0, 2'h0, 2'h1, SS, 1'b1, 16'h0);
    ck();
    for (int i = 0; i < 4; i++) begin
      se = prod(rv[2], rv[2], 2'(i + 2), 1'b0);
      sec_ovf = ov(se);
      go(OP_MUL, 1'b1, 2'h2, 2'h2, macres_sign_t'(2'(i + 2)), 1'b0, 16'h0);
      ck();
    end
    pe = pe + prod(rv[3], se[31:16], 2'h0, 1'b0);
    pv = ov(pe);
    go(OP_MAC_ADD, 1'b0, 2'h0, 2'h0, SS, 1'b0, 16'h0, 1'b0, 1'b1, 1'b1, 1'b1);
    ck();
    pe = pe - prod(rv[0], rv[1], 2'h0, 1'b0);
    pv = ov(pe);
    go(OP_MAC_SUB, 1'b0, 2'h0, 2'h1, SS, 1'b0, 16'h0);
    ck();
    $display("test multiply done");
    pv = 1'b1;
    pe = 40'h007fffffff;
    go(OP_MUL, 1'b0, 2'h2, 2'h2, UNS, 1'b0, 16'h0, 1'b0, 1'b1, 1'b0, 1'b0,
       1'b1);
    go(OP_SAT, 1'b0, 2'h0, 2'h0, SS, 1'b0, 16'h0);
    ck();
    pe = 40'h1;
    pv = 1'b0;
    go(OP_MUL, 1'b0, 2'h2, 2'h2, SS, 1'b0, 16'h0);
    ck();
    pe = {8'hff, 16'h8000, pe[15:0]};
    go(OP_LOAD_MID, 1'b0, 2'h0, 2'h0, SS, 1'b0, 16'h8000);
    ck();
    go(OP_SAT, 1'b0, 2'h0, 2'h0, SS, 1'b0, 16'h0);
    ck();
    pe[39:32] = 8'h80;
    go(OP_LOAD_TOP, 1'b0, 2'h0, 2'h0, SS, 1'b0, 16'h0080);
    ck();
    pe[15:0] = 16'h1234;
    go(OP_LOAD_LOW, 1'b0, 2'h0, 2'h0, SS, 1'b0, 16'h1234);
    ck();
    pv = ov(pe);
    go(OP_ROUND, 1'b0, 2'h0, 2'h0, SS, 1'b0, 16'h0);
    ck();
    pe = 40'hff80000000;
    go(OP_SAT, 1'b0, 2'h0, 2'h0, SS, 1'b0, 16'h0);
    ck();
    go(OP_MUL, 1'b0, 2'h2, 2'h2, SS, 1'b0, 16'h0, 1'b0, 1'b0);
    ck();
    $display("test saturate done");
    pe = 40'h0;
    pv = 1'b0;
    sec_ovf = 1'b0;
    go(OP_CLEAR, 1'b0, 2'h0, 2'h0, SS, 1'b0, 16'h0);
    ck();
    pe = prod(rv[3], rv[3], 2'h0, 1'b1) + 40'h8000;
    pv = ov(pe);
    go(OP_MUL, 1'b0, 2'h3, 2'h3, SS, 1'b1, 16'h0, 1'b1);
    ck();
    se = prod(rv[3], rv[3], 2'h0, 1'b1);
    sec_ovf = ov(se);
    go(OP_MUL, 1'b1, 2'h3, 2'h3, SS, 1'b1, 16'h0);
    ck();
    se = pe;
    go(OP_ROUND, 1'b1, 2'h0, 2'h0, SS, 1'b1, 16'h0);
    ck();
    $display("test clear and round done");
    go(OP_NOP, 1'b1, 2'h0, 2'h0, SS, 1'b0, 16'h0);
    ck();
    se = {8'h00, 16'h7fff, se[15:0]};
    go(OP_LOAD_MID, 1'b1, 2'h0, 2'h0, SS, 1'b0, 16'h7fff);
    ck();
    se[39:32] = 8'h01;
    go(OP_LOAD_TOP, 1'b1, 2'h0, 2'h0, SS, 1'b0, 16'h0001);
    ck();
    sec_ovf = ov(se);
    go(OP_ROUND, 1'b1, 2'h0, 2'h0, SS, 1'b0, 16'h0);
    ck();
    se = 40'h007fffffff;
    go(OP_SAT, 1'b1, 2'h0, 2'h0, SS, 1'b0, 16'h0);
    ck();
    se = 40'h0;
    sec_ovf = 1'b0;
    go(OP_CLEAR, 1'b1, 2'h0, 2'h0, SS, 1'b0, 16'h0);
    ck();
    $display("test secondary done");
    complete_run();
  end

  // A full run costs far less than this span
  initial begin
    repeat (2000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire

// file: verilog/macres_unit.sv
// Multiply-accumulate result unit with two 40-bit accumulators
//
// Behaviour
// - Multiply results fill all 40 bits, sign kept
// - Middle section load sign-extends into top section
// - Low section load touches nothing else
// - Clear zeroes register and both overflow flags
// - Round alters fractional results only, matches option
// - Primary overflow flag sits in status bit 6
// - Secondary overflow flag sits in status bit 8
// - Flags registered, visible the next cycle
// - Overflow when top nine bits not uniform
// - Saturate does nothing while overflow flag clear
// - Saturate positive gives 0x007fffffff
// - Saturate negative gives 0xff80000000
// - Saturation acts only in its own cycle
// - Round updates own flag; saturate none
// - 16x16 product, then add, subtract or pass
// - X operand from register file or result bus
// - Y operand from register file or feedback
// - Secondary bits 16-31 serve as feedback operand
// - Signed fractional product shifted left one bit
// - Four operand signedness combinations selectable
// - Sections are bits 0-15, 16-31, 32-39
`timescale 1ns/1ns
`default_nettype none
`include "macres_consts.svh"

module macres_unit (
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire macres_pkg::macres_cmd_t cmd,
  input  wire logic                frac_mode,
  input  wire logic [15:0]         x_regfile,
  input  wire logic [15:0]         x_result_bus,
  input  wire logic [15:0]         y_regfile,
  input  wire logic [15:0]         load_data,
  output logic      [39:0]         primary_accumulator,
  output logic      [39:0]         secondary_accumulator,
  output logic      [15:0]         secondary_acc_mid_feedback,
  output logic      [15:0]         arith_flags_register
);
  import macres_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [39:0] acc_p;
  logic [39:0] acc_s;
  logic        ovf_p;
  logic        ovf_s;
  logic [39:0] next_acc_p;
  logic [39:0] next_acc_s;
  logic        next_ovf_p;
  logic        next_ovf_s;

  logic [15:0] x_op;
  logic [15:0] y_op;
  logic        x_signed;
  logic        y_signed;
  logic [33:0] product;
  logic [39:0] prod40;
  logic [39:0] cur;
  logic        cur_ovf;
  logic [39:0] result;
  logic        write_acc;
  logic        write_flag;
  logic        exec;

  function automatic logic top_nonuniform(input logic [39:0] v);
    top_nonuniform = ~((&v[39:31]) | ~(|v[39:31]));
  endfunction

  // Rounding is shared by the multiply option and the explicit operation
  function automatic logic [39:0] round40(input logic [39:0] v,
                                          input logic        frac);
    round40 = frac ? v + `MACRES_RND_BIAS : v;
  endfunction

  // ----------------------------------------------------------------
  // Multiplier datapath
  // ----------------------------------------------------------------
  always_comb begin
    x_op = cmd.x_from_rbus ? x_result_bus : x_regfile;
    // Feedback reads the stored middle section of the secondary
    y_op = cmd.y_from_feedback ? acc_s[31:16] : y_regfile;
    x_signed = (cmd.sign_mode == both_signed_operands) ||
               (cmd.sign_mode == signed_x_unsigned_y);
    y_signed = (cmd.sign_mode == both_signed_operands) ||
               (cmd.sign_mode == unsigned_x_signed_y);
    // 17x17 signed multiply covers every signedness mix exactly
    product = 34'($signed({x_signed & x_op[15], x_op}) *
                  $signed({y_signed & y_op[15], y_op}));
    prod40 = {{6{product[33]}}, product};
    if (frac_mode && cmd.sign_mode == both_signed_operands) begin
      prod40 = {prod40[38:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Accumulate, round, saturate, load
  // ----------------------------------------------------------------
  always_comb begin
    cur        = cmd.dest_secondary ? acc_s : acc_p;
    cur_ovf    = cmd.dest_secondary ? ovf_s : ovf_p;
    result     = cur;
    write_acc  = 1'b0;
    write_flag = 1'b0;
    next_acc_p = acc_p;
    next_acc_s = acc_s;
    next_ovf_p = ovf_p;
    next_ovf_s = ovf_s;
    exec = cmd.valid && cmd.cond_true;
    if (exec) begin
      unique case (cmd.op)
        OP_NOP: begin
          write_acc = 1'b0;
        end
        OP_MUL, OP_MAC_ADD, OP_MAC_SUB: begin
          unique case (cmd.op)
            OP_MAC_ADD: result = cur + prod40;
            OP_MAC_SUB: result = cur - prod40;
            default:    result = prod40;
          endcase
          if (cmd.rnd) begin
            result = round40(result, frac_mode);
          end
          write_acc  = 1'b1;
          write_flag = 1'b1;
        end
        OP_CLEAR: begin
          result     = `MACRES_ACC_RST;
          write_acc  = 1'b1;
        end
        OP_ROUND: begin
          result     = round40(cur, frac_mode);
          write_acc  = 1'b1;
          write_flag = 1'b1;
        end
        OP_SAT: begin
          // One-shot: nothing persists past this cycle
          if (cur_ovf) begin
            result = cur[39] ? `MACRES_SAT_NEG : `MACRES_SAT_POS;
          end
          write_acc = 1'b1;
        end
        OP_LOAD_LOW: begin
          result    = {cur[39:16], load_data};
          write_acc = 1'b1;
        end
        OP_LOAD_MID: begin
          result    = {{8{load_data[15]}}, load_data, cur[15:0]};
          write_acc = 1'b1;
        end
        OP_LOAD_TOP: begin
          // A later top load overrides the middle's extension
          result    = {load_data[7:0], cur[31:0]};
          write_acc = 1'b1;
        end
        default: begin
          write_acc = 1'b0;
        end
      endcase
      if (write_acc) begin
        if (cmd.dest_secondary) begin
          next_acc_s = result;
        end else begin
          next_acc_p = result;
        end
      end
      if (write_flag) begin
        if (cmd.dest_secondary) begin
          next_ovf_s = top_nonuniform(result);
        end else begin
          next_ovf_p = top_nonuniform(result);
        end
      end
      if (cmd.op == OP_CLEAR) begin
        next_ovf_p = 1'b0;
        next_ovf_s = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_p <= `MACRES_ACC_RST;
      acc_s <= `MACRES_ACC_RST;
      ovf_p <= 1'b0;
      ovf_s <= 1'b0;
    end else begin
      acc_p <= next_acc_p;
      acc_s <= next_acc_s;
      ovf_p <= next_ovf_p;
      ovf_s <= next_ovf_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    primary_accumulator        = acc_p;
    secondary_accumulator      = acc_s;
    secondary_acc_mid_feedback = acc_s[31:16];
    arith_flags_register       = `MACRES_FLAGS_RST;
    arith_flags_register[`MACRES_PRI_OVF_BIT] = ovf_p;
    arith_flags_register[`MACRES_SEC_OVF_BIT] = ovf_s;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_sat_p;
    cmd.valid && cmd.cond_true && cmd.op == OP_SAT && !cmd.dest_secondary;
  endsequence

  sequence s_pri(macres_op_t o);
    cmd.valid && cmd.cond_true && cmd.op == o && !cmd.dest_secondary;
  endsequence

  sequence s_sec(macres_op_t o);
    cmd.valid && cmd.cond_true && cmd.op == o && cmd.dest_secondary;
  endsequence

  a_clear_all_flags: assert property (
    s_pri(OP_CLEAR) |=> acc_p == 40'h0 &&
      arith_flags_register[6] == 1'b0 && arith_flags_register[8] == 1'b0)
    else $error("clear left value or flags");

  a_low_load_only: assert property (
    s_pri(OP_LOAD_LOW) |=> acc_p[15:0] == $past(load_data) &&
      acc_p[39:16] == $past(acc_p[39:16]))
    else $error("low load disturbed upper sections");

  a_mid_load_ext: assert property (
    s_pri(OP_LOAD_MID) |=> acc_p[31:16] == $past(load_data) &&
      acc_p[39:32] == {8{$past(load_data[15])}})
    else $error("middle load not sign extended");

  a_sat_keep_flags: assert property (
    cmd.valid && cmd.op == OP_SAT |=> $stable(arith_flags_register))
    else $error("saturate changed a flag");

  a_sat_pos_value: assert property (
    s_sat_p ##0 (ovf_p && !acc_p[39]) |=> acc_p == `MACRES_SAT_POS)
    else $error("positive saturation value wrong");

  a_sat_neg_value: assert property (
    s_sat_p ##0 (ovf_p && acc_p[39]) |=> acc_p == `MACRES_SAT_NEG)
    else $error("negative saturation value wrong");

  a_sat_no_ovf: assert property (
    s_sat_p ##0 !ovf_p |=> $stable(acc_p))
    else $error("saturate acted without overflow");

  a_mul_ovf_flag: assert property (
    cmd.valid && cmd.cond_true && !cmd.dest_secondary &&
      cmd.op inside {OP_MUL, OP_MAC_ADD, OP_MAC_SUB} |=>
      arith_flags_register[6] ==
        !(acc_p[39:31] == 9'h1ff || acc_p[39:31] == 9'h000))
    else $error("primary overflow flag disagrees with result");

  a_round_integer: assert property (
    s_pri(OP_ROUND) ##0 !frac_mode |=> $stable(acc_p))
    else $error("integer round changed the value");

  a_cond_false: assert property (
    cmd.valid && !cmd.cond_true |=> $stable(acc_p) && $stable(acc_s) &&
      $stable(arith_flags_register))
    else $error("false condition changed state");

  a_sec_clear_flags: assert property (
    s_sec(OP_CLEAR) |=> acc_s == 40'h0 &&
      arith_flags_register[6] == 1'b0 && arith_flags_register[8] == 1'b0)
    else $error("secondary clear left value or flags");

  a_sec_mid_ext: assert property (
    s_sec(OP_LOAD_MID) |=> acc_s[31:16] == $past(load_data) &&
      acc_s[39:32] == {8{$past(load_data[15])}})
    else $error("secondary middle load not sign extended");

  a_round_own_flag: assert property (
    s_pri(OP_ROUND) |=> $stable(arith_flags_register[8]))
    else $error("primary round touched secondary flag");

  a_sec_round_flag: assert property (
    s_sec(OP_ROUND) |=> $stable(arith_flags_register[6]))
    else $error("secondary round touched primary flag");

  a_sec_ovf_flag: assert property (
    cmd.valid && cmd.cond_true && cmd.dest_secondary &&
      cmd.op inside {OP_MUL, OP_MAC_ADD, OP_MAC_SUB} |=>
      arith_flags_register[8] ==
        !(acc_s[39:31] == 9'h1ff || acc_s[39:31] == 9'h000))
    else $error("secondary overflow flag disagrees with result");

  a_sec_sat_pos: assert property (
    s_sec(OP_SAT) ##0 (ovf_s && !acc_s[39]) |=> acc_s == `MACRES_SAT_POS)
    else $error("secondary positive saturation value wrong");

endmodule
`default_nettype wire
